// ==== core/frsu_regs.svh ====
// float register and status unit: field positions, masks, reset and fixed values
// assumes inclusion by bare name from package or modules
`ifndef FRSU_REGS_SVH
`define FRSU_REGS_SVH

// status/control field positions
`define FRSU_SC_CV_BIT 16
`define FRSU_SC_CZ_BIT 15
`define FRSU_SC_EV_BIT 11
`define FRSU_SC_EZ_BIT 10
`define FRSU_SC_FV_BIT 6
`define FRSU_SC_FZ_BIT 5

// status/control fixed pattern and writable mask
`define FRSU_SC_FIXED 32'h00040001
`define FRSU_SC_WMASK 32'h00018C60
`define FRSU_SC_RESET 32'h00040001

// transfer register reset value
`define FRSU_XFER_RESET 32'h00000000

// special result values
`define FRSU_QNAN 32'h7FBFFFFF
`define FRSU_INF_MAG 32'h7F800000

// implicit index register of multiply-accumulate
`define FRSU_IDX_REG 4'h0

`endif

// ==== core/frsu_pkg.sv ====
// float register and status unit: shared types
// assumes frsu_regs.svh holds the numeric constants
package frsu_pkg;

    // one completed floating point instruction from the datapath
    typedef struct packed {
        logic [3:0] dst;
        logic dst_fr_we;
        logic dst_xfer_we;
        logic [31:0] result;
        logic [2:0] guard;
        logic invalid;
        logic divzero;
    } frsu_op_t;

    typedef enum logic {
        FRSU_SYS_XFER,
        FRSU_SYS_STATUS
    } frsu_sysreg_t;

    // load-system / store-system access from the core
    typedef struct packed {
        frsu_sysreg_t sel;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } frsu_sysacc_t;

endpackage : frsu_pkg

// ==== core/frsu_dnorm_flush.sv ====
// denormal flush of one single-precision value
// assumes ieee-style layout: sign, exponent, fraction
`timescale 1ns/100ps
`default_nettype none

module frsu_dnorm_flush #(
    parameter int EXP_W = 8,
    parameter int FRAC_W = 23
) (
    // value in and out
    input wire logic [EXP_W+FRAC_W:0] val_in,
    output logic [EXP_W+FRAC_W:0] val_out
);

    // zero exponent with nonzero fraction becomes signed zero
    always_comb begin
        if (val_in[EXP_W+FRAC_W-1:FRAC_W] == '0) begin
            val_out = {val_in[EXP_W+FRAC_W], {(EXP_W+FRAC_W){1'b0}}};
        end else begin
            val_out = val_in;
        end
    end

endmodule : frsu_dnorm_flush

`default_nettype wire

// ==== core/frsu_regfile.sv ====
// sixteen-entry float register file, one write port, three registered reads
// assumes single clock; contents undefined until written
`timescale 1ns/100ps
`default_nettype none
`include "frsu_regs.svh"

module frsu_regfile #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32,
    parameter int AW = 4
) (
    // clock
    input wire logic sys_clk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // read ports
    input wire logic [AW-1:0] raddr_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [WIDTH-1:0] rdata_a_ff,
    output logic [WIDTH-1:0] rdata_b_ff,
    output logic [WIDTH-1:0] rdata_idx_ff
);

    logic [WIDTH-1:0] mem_ff [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem_ff[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        rdata_a_ff <= mem_ff[raddr_a];
        rdata_b_ff <= mem_ff[raddr_b];
        rdata_idx_ff <= mem_ff[`FRSU_IDX_REG];
    end

endmodule : frsu_regfile

`default_nettype wire

// ==== core/frsu_unit.sv ====
// float register and status unit: register file, transfer and status/control
// assumes the core serialises ops and system accesses; one op per cycle at most
`timescale 1ns/100ps
`default_nettype none
`include "frsu_regs.svh"

module frsu_unit #(
    parameter int NREG = 16,
    parameter int AW = 4,
    parameter int DW = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // completed op from the datapath
    input wire logic op_valid,
    input wire frsu_pkg::frsu_op_t op,
    // operand reads
    input wire logic src_rd_en,
    input wire logic [AW-1:0] src_a_sel,
    input wire logic [AW-1:0] src_b_sel,
    output logic [DW-1:0] src_a_data_ff,
    output logic [DW-1:0] src_b_data_ff,
    output logic [DW-1:0] index_data_ff,
    output logic src_valid_ff,
    // system register access from the core
    input wire logic sys_valid,
    input wire frsu_pkg::frsu_sysacc_t sys_acc,
    output logic [DW-1:0] sys_rdata_ff,
    output logic sys_rdata_valid_ff,
    // state toward the datapath and core
    output logic [DW-1:0] transfer_ff,
    output logic [DW-1:0] status_rd,
    output logic exc_event_ff
);

    logic cv_ff;
    logic cz_ff;
    logic ev_ff;
    logic ez_ff;
    logic fv_ff;
    logic fz_ff;
    logic [DW-1:0] nxt_result;
    logic [DW-1:0] result_flushed;
    logic [DW-1:0] rf_a_raw;
    logic [DW-1:0] rf_b_raw;
    logic [DW-1:0] rf_idx_raw;
    logic [DW-1:0] src_a_flushed;
    logic [DW-1:0] src_b_flushed;
    logic [DW-1:0] idx_flushed;
    logic trap_inv;
    logic trap_dz;
    logic trap;
    logic rf_we;
    logic sys_wr_status;
    logic sys_wr_xfer;
    logic rd_pend_ff;

    assign sys_wr_status = sys_valid && sys_acc.wr && (sys_acc.sel == frsu_pkg::FRSU_SYS_STATUS);
    assign sys_wr_xfer = sys_valid && sys_acc.wr && (sys_acc.sel == frsu_pkg::FRSU_SYS_XFER);

    // exception decisions use enables in force when the op completes
    assign trap_inv = op.invalid && ev_ff;
    assign trap_dz = op.divzero && ez_ff;
    assign trap = op_valid && (trap_inv || trap_dz);

    // guard bits are dropped: truncation is round toward zero
    always_comb begin
        nxt_result = op.result;
        if (op.invalid && !ev_ff) begin
            nxt_result = `FRSU_QNAN;
        end else if (op.divzero && !ez_ff) begin
            nxt_result = `FRSU_INF_MAG | {op.result[DW-1], {(DW-1){1'b0}}};
        end
    end

    frsu_dnorm_flush #(
        .EXP_W(8),
        .FRAC_W(23)
    ) u_flush_res (
        .val_in(nxt_result),
        .val_out(result_flushed)
    );

    // destination is kept when the op traps
    assign rf_we = op_valid && op.dst_fr_we && !trap;

    frsu_regfile #(
        .DEPTH(NREG),
        .WIDTH(DW),
        .AW(AW)
    ) u_regfile (
        .sys_clk(sys_clk),
        .we(rf_we),
        .waddr(op.dst),
        .wdata(result_flushed),
        .raddr_a(src_a_sel),
        .raddr_b(src_b_sel),
        .rdata_a_ff(rf_a_raw),
        .rdata_b_ff(rf_b_raw),
        .rdata_idx_ff(rf_idx_raw)
    );

    frsu_dnorm_flush #(
        .EXP_W(8),
        .FRAC_W(23)
    ) u_flush_a (
        .val_in(rf_a_raw),
        .val_out(src_a_flushed)
    );

    frsu_dnorm_flush #(
        .EXP_W(8),
        .FRAC_W(23)
    ) u_flush_b (
        .val_in(rf_b_raw),
        .val_out(src_b_flushed)
    );

    frsu_dnorm_flush #(
        .EXP_W(8),
        .FRAC_W(23)
    ) u_flush_idx (
        .val_in(rf_idx_raw),
        .val_out(idx_flushed)
    );

    // operand pipeline: address, array read, flush register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pend_ff <= 1'b0;
            src_valid_ff <= 1'b0;
            src_a_data_ff <= 32'h00000000;
            src_b_data_ff <= 32'h00000000;
            index_data_ff <= 32'h00000000;
        end else begin
            rd_pend_ff <= src_rd_en;
            src_valid_ff <= rd_pend_ff;
            if (rd_pend_ff) begin
                src_a_data_ff <= src_a_flushed;
                src_b_data_ff <= src_b_flushed;
                index_data_ff <= idx_flushed;
            end
        end
    end

    // transfer register: op result or core load, op wins on a clash
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            transfer_ff <= `FRSU_XFER_RESET;
        end else if (op_valid && op.dst_xfer_we && !trap) begin
            transfer_ff <= result_flushed;
        end else if (sys_wr_xfer) begin
            transfer_ff <= sys_acc.wdata;
        end
    end

    // cause bits: rewritten by every op, else loadable by software
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cv_ff <= 1'b0;
            cz_ff <= 1'b0;
        end else if (op_valid) begin
            cv_ff <= op.invalid;
            cz_ff <= op.divzero;
        end else if (sys_wr_status) begin
            cv_ff <= sys_acc.wdata[`FRSU_SC_CV_BIT];
            cz_ff <= sys_acc.wdata[`FRSU_SC_CZ_BIT];
        end
    end

    // enable bits: software only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_ff <= 1'b0;
            ez_ff <= 1'b0;
        end else if (sys_wr_status) begin
            ev_ff <= sys_acc.wdata[`FRSU_SC_EV_BIT];
            ez_ff <= sys_acc.wdata[`FRSU_SC_EZ_BIT];
        end
    end

    // sticky flags: op sets win over a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fv_ff <= 1'b0;
            fz_ff <= 1'b0;
        end else begin
            fv_ff <= (sys_wr_status ? sys_acc.wdata[`FRSU_SC_FV_BIT] : fv_ff)
                     || (op_valid && op.invalid);
            fz_ff <= (sys_wr_status ? sys_acc.wdata[`FRSU_SC_FZ_BIT] : fz_ff)
                     || (op_valid && op.divzero);
        end
    end

    // status view: fixed pattern plus live fields
    always_comb begin
        status_rd = `FRSU_SC_FIXED;
        status_rd[`FRSU_SC_CV_BIT] = cv_ff;
        status_rd[`FRSU_SC_CZ_BIT] = cz_ff;
        status_rd[`FRSU_SC_EV_BIT] = ev_ff;
        status_rd[`FRSU_SC_EZ_BIT] = ez_ff;
        status_rd[`FRSU_SC_FV_BIT] = fv_ff;
        status_rd[`FRSU_SC_FZ_BIT] = fz_ff;
    end

    // store-system read, one cycle after the request
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_rdata_ff <= 32'h00000000;
            sys_rdata_valid_ff <= 1'b0;
        end else begin
            sys_rdata_valid_ff <= sys_valid && sys_acc.rd;
            if (sys_valid && sys_acc.rd) begin
                if (sys_acc.sel == frsu_pkg::FRSU_SYS_STATUS) begin
                    sys_rdata_ff <= status_rd;
                end else begin
                    sys_rdata_ff <= transfer_ff;
                end
            end
        end
    end

    // one common exception event
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            exc_event_ff <= 1'b0;
        end else begin
            exc_event_ff <= trap;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence seq_rd_req;
        src_rd_en;
    endsequence

    sequence seq_rd_done;
        ##2 src_valid_ff;
    endsequence

    sequence seq_sys_status_rd;
        sys_valid && sys_acc.rd && (sys_acc.sel == frsu_pkg::FRSU_SYS_STATUS);
    endsequence

    AST_CAUSE_REWRITE: assert property (op_valid |=> (cv_ff == $past(op.invalid)) && (cz_ff == $past(op.divzero)))
        else $error("cause bits not rewritten by op");
    AST_EXC_RAISE: assert property (trap |=> exc_event_ff)
        else $error("enabled exception did not raise event");
    AST_EXC_ONLY: assert property (!trap |=> !exc_event_ff)
        else $error("exception event without enabled cause");
    AST_FLAG_SET: assert property (op_valid && op.invalid |=> fv_ff)
        else $error("invalid flag not set");
    AST_FLAG_HOLD: assert property (fz_ff && !sys_wr_status |=> fz_ff)
        else $error("divide flag cleared without store");
    AST_KEEP_DEST: assert property (op_valid && op.invalid && ev_ff |-> !rf_we)
        else $error("trapped op wrote destination");
    AST_QNAN: assert property (op_valid && op.invalid && !ev_ff && op.dst_xfer_we |=> transfer_ff == `FRSU_QNAN)
        else $error("disabled invalid op did not give quiet NaN");
    AST_FIXED_BITS: assert property ((status_rd & ~`FRSU_SC_WMASK) == `FRSU_SC_FIXED)
        else $error("fixed status bits changed");
    AST_ENABLE_WR: assert property (sys_wr_status |=> ev_ff == $past(sys_acc.wdata[`FRSU_SC_EV_BIT]))
        else $error("enable write lost");
    AST_STATUS_RD: assert property (seq_sys_status_rd |=> sys_rdata_valid_ff && sys_rdata_ff == $past(status_rd))
        else $error("status read returned stale fields");
    AST_SRC_LAT: assert property (seq_rd_req |-> seq_rd_done)
        else $error("operand read latency wrong");
    AST_DZ_FLAG_SET: assert property (op_valid && op.divzero |=> fz_ff)
        else $error("divide flag not set");
    AST_INV_FLAG_HOLD: assert property (fv_ff && !sys_wr_status |=> fv_ff)
        else $error("invalid flag cleared without store");
    AST_INF: assert property (op_valid && op.divzero && !op.invalid && !ez_ff && op.dst_xfer_we
        |=> transfer_ff == (`FRSU_INF_MAG | {$past(op.result[DW-1]), {(DW-1){1'b0}}}))
        else $error("disabled divide by zero did not give signed infinity");
    AST_XFER_LOAD: assert property (sys_wr_xfer && !(op_valid && op.dst_xfer_we) |=> transfer_ff == $past(sys_acc.wdata))
        else $error("core load of transfer register lost");

endmodule : frsu_unit

`default_nettype wire

// ==== tb/frsu_core_model.sv ====
// integer core model: load-system and store-system accesses
// assumes one access at a time; read data registered at the taking edge
`timescale 1ns/100ps
`default_nettype none

module frsu_core_model (
    // clock
    input wire logic sys_clk,
    // system register access
    output logic sys_valid,
    output frsu_pkg::frsu_sysacc_t sys_acc,
    input wire logic [31:0] sys_rdata_ff,
    input wire logic sys_rdata_valid_ff
);
    int gap = 0;
    logic [31:0] saved_sc = 32'h0;
    logic [31:0] dummy;

    initial begin
        sys_valid = 1'b0;
        sys_acc = '{sel: frsu_pkg::FRSU_SYS_XFER, wr: 1'b0, rd: 1'b0, wdata: 32'hA5A5A5A5};
    end

    // one system access; gap idles first to model a slow core
    task automatic xfer_acc(input frsu_pkg::frsu_sysreg_t s, input logic w, input logic [31:0] wd,
                            output logic [31:0] rd);
        int n;
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        sys_valid = 1'b1;
        sys_acc = '{sel: s, wr: w, rd: !w, wdata: wd};
        @(posedge sys_clk);
        #1;
        sys_valid = 1'b0;
        sys_acc = '{sel: s, wr: 1'b0, rd: 1'b0, wdata: ~wd};
        for (n = 0; n < 4 && !w && sys_rdata_valid_ff !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        rd = (sys_rdata_valid_ff === 1'b1 || w) ? sys_rdata_ff : 'x;
    endtask : xfer_acc

    // process context save and restore of status/control
    task automatic ctx_save();
        xfer_acc(frsu_pkg::FRSU_SYS_STATUS, 1'b0, 32'h0, saved_sc);
    endtask : ctx_save

    task automatic ctx_restore();
        xfer_acc(frsu_pkg::FRSU_SYS_STATUS, 1'b1, saved_sc, dummy);
    endtask : ctx_restore
endmodule : frsu_core_model
`default_nettype wire

// ==== tb/tb_fpu_register_and_status_unit.sv ====
// testbench of the float register and status unit
// assumes frsu_core_model stands in for the integer core
`timescale 1ns/100ps
`default_nettype none
`include "frsu_regs.svh"

module tb_fpu_register_and_status_unit;
    localparam logic [31:0] FX = `FRSU_SC_FIXED;
    localparam logic [31:0] CV = 32'h1 << `FRSU_SC_CV_BIT;
    localparam logic [31:0] CZ = 32'h1 << `FRSU_SC_CZ_BIT;
    localparam logic [31:0] EV = 32'h1 << `FRSU_SC_EV_BIT;
    localparam logic [31:0] EZ = 32'h1 << `FRSU_SC_EZ_BIT;
    localparam logic [31:0] FV = 32'h1 << `FRSU_SC_FV_BIT;
    localparam logic [31:0] FZ = 32'h1 << `FRSU_SC_FZ_BIT;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic op_valid = 1'b0;
    frsu_pkg::frsu_op_t op = '0;
    logic src_rd_en = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [31:0] a_d, b_d, i_d, x_d, s_rd, r_d, rdat;
    logic sv, rv, ev, evt, sys_v;
    frsu_pkg::frsu_sysacc_t acc;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;

    always #20 sys_clk = ~sys_clk;

    frsu_unit dut (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid), .op(op), .src_rd_en(src_rd_en),
        .src_a_sel(sel), .src_b_sel(sel), .src_a_data_ff(a_d), .src_b_data_ff(b_d), .index_data_ff(i_d),
        .src_valid_ff(sv), .sys_valid(sys_v), .sys_acc(acc), .sys_rdata_ff(r_d), .sys_rdata_valid_ff(rv),
        .transfer_ff(x_d), .status_rd(s_rd), .exc_event_ff(ev));
    frsu_core_model core (.sys_clk(sys_clk), .sys_valid(sys_v), .sys_acc(acc), .sys_rdata_ff(r_d),
        .sys_rdata_valid_ff(rv));

    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic do_op(input logic [3:0] d, input logic xw, input logic [31:0] r, input logic [2:0] g,
                         input logic iv, input logic dz);
        @(posedge sys_clk);
        #1;
        op_valid = 1'b1;
        op = '{dst: d, dst_fr_we: !xw, dst_xfer_we: xw, result: r, guard: g, invalid: iv, divzero: dz};
        @(posedge sys_clk);
        #1;
        op_valid = 1'b0;
        evt = ev;
    endtask : do_op

    task automatic rd_fr(input logic [3:0] s, input logic [31:0] exp);
        int n;
        @(posedge sys_clk);
        #1;
        src_rd_en = 1'b1;
        sel = s;
        @(posedge sys_clk);
        #1;
        src_rd_en = 1'b0;
        sel = ~s;
        for (n = 0; n < 4 && sv !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        check("src_valid", {31'h0, sv}, 32'h1);
        check("src_a", a_d, exp);
        check("src_b", b_d, exp);
    endtask : rd_fr

    task automatic st_chk(input logic [31:0] exp);
        core.xfer_acc(frsu_pkg::FRSU_SYS_STATUS, 1'b0, 32'h0, rdat);
        check("status", rdat, exp);
        check("status_live", s_rd, exp);
    endtask : st_chk

    task automatic st_wr(input logic [31:0] w);
        core.xfer_acc(frsu_pkg::FRSU_SYS_STATUS, 1'b1, w, rdat);
    endtask : st_wr

    task automatic t_fixed();
        check("xfer_reset", x_d, `FRSU_XFER_RESET);
        st_chk(`FRSU_SC_RESET);
        st_wr(32'hFFFFFFFF);
        st_chk(FX | `FRSU_SC_WMASK);
        st_wr(32'h00000000);
        st_chk(FX);
    endtask : t_fixed

    task automatic t_regs();
        for (int i = 0; i < 16; i++) do_op(i[3:0], 1'b0, 32'h40000000 | (i << 4), 3'h0, 1'b0, 1'b0);
        for (int i = 15; i >= 0; i--) rd_fr(i[3:0], 32'h40000000 | (i << 4));
        check("index", i_d, 32'h40000000);
    endtask : t_regs

    task automatic t_disabled();
        do_op(4'h2, 1'b0, 32'h3F800000, 3'h0, 1'b1, 1'b0);
        check("no_trap_iv", {31'h0, evt}, 32'h0);
        st_chk(FX | CV | FV);
        do_op(4'h3, 1'b0, 32'h80000000, 3'h0, 1'b0, 1'b1);
        check("no_trap_dz", {31'h0, evt}, 32'h0);
        st_chk(FX | CZ | FV | FZ);
        do_op(4'h0, 1'b1, 32'h00000000, 3'h0, 1'b1, 1'b0);
        check("xfer_qnan", x_d, `FRSU_QNAN);
        do_op(4'h0, 1'b1, 32'h00000000, 3'h0, 1'b0, 1'b1);
        check("xfer_inf", x_d, 32'h7F800000);
        do_op(4'h4, 1'b0, 32'h3F800001, 3'h7, 1'b0, 1'b0);
        do_op(4'h5, 1'b0, 32'h80000001, 3'h0, 1'b0, 1'b0);
        st_chk(FX | FV | FZ);
        rd_fr(4'h2, `FRSU_QNAN);
        rd_fr(4'h3, 32'hFF800000);
        rd_fr(4'h4, 32'h3F800001);
        rd_fr(4'h5, 32'h80000000);
    endtask : t_disabled

    task automatic t_ctx();
        core.ctx_save();
        st_wr(32'h00000000);
        st_chk(FX);
        core.ctx_restore();
        st_chk(FX | FV | FZ);
    endtask : t_ctx

    task automatic t_trap();
        st_wr(EV | EZ);
        do_op(4'h6, 1'b0, 32'h40400000, 3'h0, 1'b0, 1'b0);
        check("no_exc", {31'h0, evt}, 32'h0);
        do_op(4'h6, 1'b0, 32'h11111111, 3'h0, 1'b1, 1'b0);
        check("trap_iv", {31'h0, evt}, 32'h1);
        st_chk(FX | EV | EZ | CV | FV);
        do_op(4'h6, 1'b0, 32'h22222222, 3'h0, 1'b0, 1'b1);
        check("trap_dz", {31'h0, evt}, 32'h1);
        rd_fr(4'h6, 32'h40400000);
    endtask : t_trap

    task automatic t_xfer();
        core.gap = 2;
        core.xfer_acc(frsu_pkg::FRSU_SYS_XFER, 1'b1, 32'h12345678, rdat);
        check("xfer_load", x_d, 32'h12345678);
        do_op(4'h0, 1'b1, 32'hC0000000, 3'h0, 1'b0, 1'b0);
        core.xfer_acc(frsu_pkg::FRSU_SYS_XFER, 1'b0, 32'h0, rdat);
        check("xfer_store", rdat, 32'hC0000000);
        core.gap = 0;
    endtask : t_xfer

    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_fixed();
        t_regs();
        t_disabled();
        t_ctx();
        t_trap();
        t_xfer();
        finish_test();
    end
endmodule : tb_fpu_register_and_status_unit
`default_nettype wire
